// [common/adcseq_map.svh]
// register map, field positions, reset values and cycle counts of the conversion sequencer
`ifndef ADCSEQ_MAP_SVH
`define ADCSEQ_MAP_SVH
// ==========================================================
// register byte offsets
`define ADCSEQ_OFF_CTRL_A 8'h00
`define ADCSEQ_OFF_CTRL_B 8'h04
`define ADCSEQ_OFF_SEL 8'h08
`define ADCSEQ_OFF_RES_LO 8'h0c
`define ADCSEQ_OFF_RES_HI 8'h10
// ==========================================================
// converter_control_status_a fields
`define ADCSEQ_A_EN 7
`define ADCSEQ_A_START 6
`define ADCSEQ_A_AUTO 5
`define ADCSEQ_A_FLAG 4
`define ADCSEQ_A_IE 3
`define ADCSEQ_A_DIV_HI 2
`define ADCSEQ_A_DIV_LO 0
// converter_control_status_b fields
`define ADCSEQ_B_SRC_HI 2
`define ADCSEQ_B_SRC_LO 0
// input_reference_select fields
`define ADCSEQ_S_REF_HI 7
`define ADCSEQ_S_REF_LO 6
`define ADCSEQ_S_LADJ 5
`define ADCSEQ_S_CH_HI 4
`define ADCSEQ_S_CH_LO 0
`define ADCSEQ_S_DIFF 4
// ==========================================================
// reset values
`define ADCSEQ_RST_SEL 8'h00
`define ADCSEQ_RST_DIV 3'h0
`define ADCSEQ_RST_SRC 3'h0
// trigger source that means restart on own completion
`define ADCSEQ_SRC_FREE 3'h0
// ==========================================================
// conversion lengths and sample points, in conversion clock cycles
`define ADCSEQ_LEN_NORM 5'd13
`define ADCSEQ_LEN_FIRST 5'd25
`define ADCSEQ_LEN_DIFF_HI 5'd14
`define ADCSEQ_SMP_NORM 5'd1
`define ADCSEQ_SMP_FIRST 5'd13
`define ADCSEQ_SMP_AUTO 5'd2
`define ADCSEQ_SMP_DIFF_HI 5'd2
// cpu cycles of trigger synchronisation, minus one
`define ADCSEQ_SYNC_LAST 5'd2
`endif

// [common/adcseq_pkg.sv]
// types shared by the conversion sequencer
`default_nettype none
package adcseq_pkg;
  // ==========================================================
  // sequencer states, one-hot
  typedef enum logic [3:0] {
    ADCSEQ_IDLE = 4'b0001,
    ADCSEQ_WAIT = 4'b0010,
    ADCSEQ_SYNC = 4'b0100,
    ADCSEQ_CONV = 4'b1000
  } adcseq_state_t;
endpackage : adcseq_pkg
`default_nettype wire

// [verilog/adcseq_prescaler.sv]
// conversion clock prescaler: rising-edge tick and half-rate clock level
`default_nettype none
module adcseq_prescaler #(
  parameter int CNT_W = 7
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic clr_i,
  input wire logic [2:0] div_sel_i,
  output logic tick_o,
  output logic half_clk_o
);
  // ==========================================================
  // divide ratio: selects 0 and 1 both divide by two
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W:0] pow_w;
  logic [CNT_W-1:0] limit_w;
  assign pow_w = (CNT_W+1)'(1) << div_sel_i;
  assign limit_w = (div_sel_i == 3'h0) ? CNT_W'(1) : CNT_W'(pow_w - (CNT_W+1)'(1));
  wire hold_w = ~en_i | clr_i;
  // at or past the limit: a smaller divider written mid-count must not
  // leave the counter above its new limit for a full roll-over
  wire wrap_w = (cnt_r >= limit_w);
  // ==========================================================
  // counter held at zero while off or cleared by a trigger
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || hold_w) begin
      cnt_r <= '0;
      tick_o <= 1'b0;
      half_clk_o <= 1'b0;
    end else begin
      cnt_r <= wrap_w ? '0 : cnt_r + CNT_W'(1);
      tick_o <= wrap_w;
      // half-rate clock flips at each conversion clock rise
      half_clk_o <= wrap_w ? ~half_clk_o : half_clk_o;
    end
  end
endmodule : adcseq_prescaler
`default_nettype wire

// [verilog/adcseq_top.sv]
// conversion sequencer for a 10-bit successive approximation converter, APB slave
//
// Added by the designer: the APB register port and the placing of the registers.
`default_nettype none
`include "adcseq_map.svh"
module adcseq_top
  import adcseq_pkg::*;
#(
  parameter int PRESC_W = 7,
  parameter int TRIG_N = 8
) (
  input wire logic REF_CLK_I,
  input wire logic RESET_N_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // trigger sources from on-chip logic, same clock
  input wire logic [TRIG_N-1:0] TRIG_I,
  // converter side
  input wire logic [9:0] CONV_RESULT_I,
  output logic CONV_ENABLE_O,
  output logic [4:0] CONV_CHANNEL_O,
  output logic [1:0] CONV_REFERENCE_O,
  output logic CONV_SAMPLE_O,
  output logic CONV_BUSY_O,
  output logic CONV_DONE_O,
  output logic CONV_IRQ_O
);
  // ==========================================================
  // apb decode
  wire setup_w = PSEL_I & ~PENABLE_I;
  wire acc_w = PSEL_I & PENABLE_I;
  wire hit_a_w = (PADDR_I == `ADCSEQ_OFF_CTRL_A);
  wire hit_b_w = (PADDR_I == `ADCSEQ_OFF_CTRL_B);
  wire hit_s_w = (PADDR_I == `ADCSEQ_OFF_SEL);
  wire hit_l_w = (PADDR_I == `ADCSEQ_OFF_RES_LO);
  wire hit_h_w = (PADDR_I == `ADCSEQ_OFF_RES_HI);
  wire mapped_w = hit_a_w | hit_b_w | hit_s_w | hit_l_w | hit_h_w;
  wire wr_w = acc_w & PWRITE_I;
  wire rd_w = acc_w & ~PWRITE_I;
  wire wr_a_w = wr_w & hit_a_w;
  // zero wait states; unmapped addresses answer with an error
  assign PREADY_O = acc_w;
  assign PSLVERR_O = acc_w & ~mapped_w;

  // ==========================================================
  // software-visible state
  logic en_r; // converter_enable
  logic auto_r; // auto_trigger_enable
  logic flag_r; // conversion_done_flag
  logic ie_r; // interrupt enable
  logic [2:0] div_r; // clock_divider_select
  logic [2:0] src_r; // trigger_source_select
  logic [7:0] sel_r; // input_reference_select as written
  logic [7:0] act_r; // selection seen by the converter
  logic [9:0] res_r; // last stored result
  logic lock_r; // data bytes blocked after low read
  logic first_r; // next conversion is the extended one
  logic [31:0] prdata_r; // read data captured in setup
  // sequencer
  adcseq_state_t state_r;
  adcseq_state_t st_nxt;
  logic [4:0] cnt_r; // cycles counted in current state
  logic [4:0] cnt_nxt;
  logic [4:0] len_r; // length of running conversion
  logic [4:0] len_nxt;
  logic [4:0] smp_r; // sample point of running conversion
  logic [4:0] smp_nxt;
  logic trig_prev_r; // selected trigger one cycle ago
  logic sample_r; // sample strobe to converter
  logic done_r; // completion strobe
  // prescaler outputs
  logic tick_w;
  logic half_w;

  // ==========================================================
  // control decode
  wire en_nxt = wr_a_w ? PWDATA_I[`ADCSEQ_A_EN] : en_r;
  wire en_rise_w = en_nxt & ~en_r;
  wire sw_start_w = wr_a_w & PWDATA_I[`ADCSEQ_A_START] & PWDATA_I[`ADCSEQ_A_EN];
  wire free_w = auto_r & (src_r == `ADCSEQ_SRC_FREE);
  wire diff_w = sel_r[`ADCSEQ_S_DIFF];
  wire idle_w = (state_r == ADCSEQ_IDLE);
  wire conv_w = (state_r == ADCSEQ_CONV);
  wire last_cyc_w = conv_w & (cnt_r == len_r - 5'd1);
  wire done_w = last_cyc_w & tick_w;
  wire start_rd_w = ~idle_w;
  // flag sources set their own flag whatever the interrupt
  // enables; edge detection means a flag left set blocks re-triggering
  wire trig_lvl_w = TRIG_I[src_r];
  // level held across completion gives no edge, so no restart
  wire trig_edge_w = en_r & auto_r & (src_r != `ADCSEQ_SRC_FREE)
                   & trig_lvl_w & ~trig_prev_r;
  wire presc_clr_w = idle_w & trig_edge_w;

  // ==========================================================
  // prescaler
  adcseq_prescaler #(
    .CNT_W(PRESC_W)
  ) u_presc (
    .clk_i(REF_CLK_I),
    .rst_n_i(RESET_N_I),
    .en_i(en_r),
    .clr_i(presc_clr_w),
    .div_sel_i(div_r),
    .tick_o(tick_w),
    .half_clk_o(half_w)
  );

  // ==========================================================
  // next state of the sequencer
  always_comb begin
    st_nxt = state_r;
    cnt_nxt = cnt_r;
    len_nxt = len_r;
    smp_nxt = smp_r;
    unique case (state_r)
      ADCSEQ_IDLE: begin
        if (trig_edge_w) begin
          // trigger wins over a start written the same cycle
          st_nxt = ADCSEQ_SYNC;
          cnt_nxt = 5'd0;
        end else if (sw_start_w) begin
          st_nxt = ADCSEQ_WAIT;
        end
      end
      ADCSEQ_WAIT: begin
        // conversion opens on the next conversion clock rise
        if (tick_w) begin
          st_nxt = ADCSEQ_CONV;
          cnt_nxt = 5'd0;
          if (first_r) begin
            len_nxt = `ADCSEQ_LEN_FIRST;
            smp_nxt = `ADCSEQ_SMP_FIRST;
          end else if (diff_w && half_w) begin
            len_nxt = `ADCSEQ_LEN_DIFF_HI;
            smp_nxt = `ADCSEQ_SMP_DIFF_HI;
          end else begin
            len_nxt = `ADCSEQ_LEN_NORM;
            smp_nxt = `ADCSEQ_SMP_NORM;
          end
        end
      end
      ADCSEQ_SYNC: begin
        // three cpu cycles between trigger edge and conversion
        if (cnt_r == `ADCSEQ_SYNC_LAST) begin
          st_nxt = ADCSEQ_CONV;
          cnt_nxt = 5'd0;
          len_nxt = first_r ? `ADCSEQ_LEN_FIRST : `ADCSEQ_LEN_NORM;
          smp_nxt = first_r ? `ADCSEQ_SMP_FIRST : `ADCSEQ_SMP_AUTO;
        end else begin
          cnt_nxt = cnt_r + 5'd1;
        end
      end
      ADCSEQ_CONV: begin
        if (done_w) begin
          cnt_nxt = 5'd0;
          if (free_w) begin
            // half-rate clock is high here, so differential takes 14
            len_nxt = diff_w ? `ADCSEQ_LEN_DIFF_HI : `ADCSEQ_LEN_NORM;
            smp_nxt = diff_w ? `ADCSEQ_SMP_DIFF_HI : `ADCSEQ_SMP_NORM;
          end else begin
            st_nxt = ADCSEQ_IDLE;
          end
        end else if (tick_w) begin
          cnt_nxt = cnt_r + 5'd1;
        end
      end
      default: begin
        st_nxt = ADCSEQ_IDLE;
        cnt_nxt = 5'd0;
      end
    endcase
    // switching off abandons any conversion or request
    if (!en_nxt) begin
      st_nxt = ADCSEQ_IDLE;
    end
  end

  // ==========================================================
  // sequencer registers
  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      state_r <= ADCSEQ_IDLE;
      cnt_r <= 5'd0;
      len_r <= `ADCSEQ_LEN_NORM;
      smp_r <= `ADCSEQ_SMP_NORM;
      trig_prev_r <= 1'b0;
    end else begin
      state_r <= st_nxt;
      cnt_r <= cnt_nxt;
      len_r <= len_nxt;
      smp_r <= smp_nxt;
      trig_prev_r <= trig_lvl_w;
    end
  end

  // ==========================================================
  // strobes to the converter
  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      sample_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      // sample point rounded to the conversion clock rise
      sample_r <= conv_w & tick_w & (cnt_r == smp_r);
      done_r <= done_w;
    end
  end

  // ==========================================================
  // control registers written over apb
  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      en_r <= 1'b0;
      auto_r <= 1'b0;
      ie_r <= 1'b0;
      div_r <= `ADCSEQ_RST_DIV;
      src_r <= `ADCSEQ_RST_SRC;
      sel_r <= `ADCSEQ_RST_SEL;
    end else begin
      if (wr_a_w) begin
        en_r <= PWDATA_I[`ADCSEQ_A_EN];
        auto_r <= PWDATA_I[`ADCSEQ_A_AUTO];
        ie_r <= PWDATA_I[`ADCSEQ_A_IE];
        div_r <= PWDATA_I[`ADCSEQ_A_DIV_HI:`ADCSEQ_A_DIV_LO];
      end
      if (wr_w && hit_b_w) begin
        src_r <= PWDATA_I[`ADCSEQ_B_SRC_HI:`ADCSEQ_B_SRC_LO];
      end
      if (wr_w && hit_s_w) begin
        sel_r <= PWDATA_I[7:0];
      end
    end
  end

  // ==========================================================
  // done flag: hardware set beats a write-one clear in the same cycle
  wire flag_clr_w = wr_a_w & PWDATA_I[`ADCSEQ_A_FLAG];
  // the extended conversion follows each switch-on
  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      flag_r <= 1'b0;
      first_r <= 1'b0;
    end else begin
      flag_r <= done_w | (flag_r & ~flag_clr_w);
      if (en_rise_w) begin
        first_r <= 1'b1;
      end else if (done_w) begin
        first_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // selection seen by the converter follows writes except
  // from a conversion start up to its last cycle
  wire act_upd_w = ~conv_w | last_cyc_w;
  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      act_r <= `ADCSEQ_RST_SEL;
    end else if (act_upd_w) begin
      act_r <= sel_r;
    end
  end

  // ==========================================================
  // result store and read lock
  wire rd_lo_w = rd_w & hit_l_w;
  wire rd_hi_w = rd_w & hit_h_w;
  // a low read in the completion cycle already counts as locked
  wire store_w = done_w & ~lock_r & ~rd_lo_w;
  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      res_r <= 10'h000;
      lock_r <= 1'b0;
    end else begin
      if (store_w) begin
        res_r <= CONV_RESULT_I;
      end
      if (rd_lo_w) begin
        lock_r <= 1'b1;
      end else if (rd_hi_w) begin
        lock_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // read data: result bytes follow the adjust bit at read time
  wire ladj_w = sel_r[`ADCSEQ_S_LADJ];
  wire [7:0] res_lo_w = ladj_w ? {res_r[1:0], 6'h00} : res_r[7:0];
  wire [7:0] res_hi_w = ladj_w ? res_r[9:2] : {6'h00, res_r[9:8]};
  wire [7:0] ctrl_a_w = {en_r, start_rd_w, auto_r, flag_r, ie_r, div_r};
  wire [7:0] rd_byte_w = hit_a_w ? ctrl_a_w :
                         hit_b_w ? {5'h00, src_r} :
                         hit_s_w ? sel_r :
                         hit_l_w ? res_lo_w :
                         hit_h_w ? res_hi_w : 8'h00;
  // captured in setup so the data output comes from a flop
  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup_w) begin
      prdata_r <= {24'h00_0000, rd_byte_w};
    end
  end
  assign PRDATA_O = prdata_r;

  // ==========================================================
  // converter outputs: selections held off while disabled
  assign CONV_ENABLE_O = en_r;
  assign CONV_CHANNEL_O = en_r ? act_r[`ADCSEQ_S_CH_HI:`ADCSEQ_S_CH_LO] : 5'h00;
  assign CONV_REFERENCE_O = en_r ? act_r[`ADCSEQ_S_REF_HI:`ADCSEQ_S_REF_LO] : 2'h0;
  assign CONV_SAMPLE_O = sample_r;
  assign CONV_BUSY_O = conv_w;
  assign CONV_DONE_O = done_r;
  // request raised even when the result was dropped by the lock
  assign CONV_IRQ_O = flag_r & ie_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RESET_N_I);

  sequence s_sync_run;
    (state_r == ADCSEQ_SYNC) [*3] ##1 (state_r == ADCSEQ_CONV);
  endsequence
  sequence s_wait_open;
    (state_r == ADCSEQ_WAIT) && tick_w && en_r && !wr_a_w;
  endsequence

  a_sel_gated: assert property (!en_r |-> CONV_CHANNEL_O == 5'h00 && CONV_REFERENCE_O == 2'h0)
    else $error("selection leaks while disabled");
  a_lock_keeps: assert property (lock_r && done_w |=> $stable(res_r))
    else $error("locked result overwritten");
  a_done_flag: assert property (done_w |=> flag_r && done_r)
    else $error("completion did not set flag");
  a_start_busy: assert property (state_r != ADCSEQ_IDLE |-> ctrl_a_w[`ADCSEQ_A_START])
    else $error("start bit low while busy");
  a_wait_tick: assert property (s_wait_open |=> state_r == ADCSEQ_CONV && cnt_r == 5'd0)
    else $error("start not taken at clock rise");
  a_trig_sync: assert property (idle_w && trig_edge_w && !wr_a_w |=> s_sync_run)
    else $error("trigger path not three cycles");
  a_first_len: assert property ((first_r and s_wait_open) |=> len_r == 5'd25)
    else $error("first conversion not extended");
  a_free_run: assert property (done_w && free_w && !wr_a_w |=> conv_w && cnt_r == 5'd0)
    else $error("free running did not restart");
  a_single_end: assert property (done_w && !free_w && !wr_a_w |=> idle_w)
    else $error("single conversion did not end");
  a_sel_locked: assert property (conv_w && !last_cyc_w |=> $stable(act_r))
    else $error("selection changed mid conversion");
  a_diff_len: assert property (((!first_r && diff_w && half_w) and s_wait_open)
                               |=> len_r == 5'd14)
    else $error("differential high start not 14");
  a_edge_ignored: assert property (conv_w && trig_edge_w && !done_w |=> conv_w)
    else $error("trigger disturbed running conversion");

endmodule : adcseq_top
`default_nettype wire

// [tb/test_adc_conversion_sequencer.sv]
// self-checking bench for the conversion sequencer, driven over its register bus
`default_nettype none
`include "adcseq_map.svh"
module test_adc_conversion_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // register offsets, short local names
  localparam logic [7:0] OFF_A = `ADCSEQ_OFF_CTRL_A;
  localparam logic [7:0] OFF_B = `ADCSEQ_OFF_CTRL_B;
  localparam logic [7:0] OFF_S = `ADCSEQ_OFF_SEL;
  localparam logic [7:0] OFF_LO = `ADCSEQ_OFF_RES_LO;
  localparam logic [7:0] OFF_HI = `ADCSEQ_OFF_RES_HI;
  // ==========================================================
  // stimulus, all given a value at time zero
  logic clk = 1'b0;
  logic rst_n = 1'b0; // active low, synchronous
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] trig = 8'h00; // trigger levels, one per source
  logic [9:0] res_in = 10'h000; // converter result
  // design outputs
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic c_en;
  logic [4:0] c_ch;
  logic [1:0] c_ref;
  logic c_smp;
  logic c_busy;
  logic c_done;
  logic c_irq;
  // bookkeeping
  int err_count = 0;
  int n_compared = 0;
  int seed = 65738;
  int cyc = 0; // free cycle count
  int done_cnt = 0; // completion pulses seen
  int done_at = 0; // cycle of the last completion pulse
  int smp_cnt = 0; // sample pulses seen
  // ==========================================================
  // clock
  always #10 clk = ~clk;
  adcseq_top i_dut (
    .REF_CLK_I(clk),
    .RESET_N_I(rst_n),
    .PSEL_I(psel),
    .PENABLE_I(penable),
    .PWRITE_I(pwrite),
    .PADDR_I(paddr),
    .PWDATA_I(pwdata),
    .PRDATA_O(prdata),
    .PREADY_O(pready),
    .PSLVERR_O(pslverr),
    .TRIG_I(trig),
    .CONV_RESULT_I(res_in),
    .CONV_ENABLE_O(c_en),
    .CONV_CHANNEL_O(c_ch),
    .CONV_REFERENCE_O(c_ref),
    .CONV_SAMPLE_O(c_smp),
    .CONV_BUSY_O(c_busy),
    .CONV_DONE_O(c_done),
    .CONV_IRQ_O(c_irq)
  );
  // ==========================================================
  // pulse monitor: one process, so the cycle stamp never races the count
  always @(posedge clk) begin
    cyc++;
    if (c_done === 1'b1) begin
      done_cnt++;
      done_at = cyc;
    end
    if (c_smp === 1'b1) begin
      smp_cnt++;
    end
  end
  // ==========================================================
  // compare tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // measured span against a window; tick phase makes it inexact
  task automatic chk_span(input int got, input int lo, input int hi);
    n_compared++;
    if (got < lo || got > hi) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : chk_span
  // ==========================================================
  // bus master: setup, then access held until pready at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no wait-state count assumed: only the watchdog ends this wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic e;
    apb(1'b1, a, d, x, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] x);
    logic e;
    apb(1'b0, a, 32'h0, x, e);
  endtask : rd
  // ==========================================================
  // expectation helpers
  // control word with enable and interrupt enable always set
  function automatic logic [31:0] ca(input logic st, au, fc, input logic [2:0] dv);
    return {24'h0, 1'b1, st, au, fc, 1'b1, dv};
  endfunction : ca
  // one result byte, formatted as the adjust bit says
  function automatic logic [31:0] rbyte(input logic [9:0] r, input logic la, hi);
    logic [15:0] w;
    w = la ? {r, 6'h00} : {6'h00, r};
    return hi ? {24'h0, w[15:8]} : {24'h0, w[7:0]};
  endfunction : rbyte
  // wait for the completion count to move, bounded
  task automatic wait_done(input int d0);
    int n;
    n = 0;
    while (done_cnt == d0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    // a completion that never comes counts as a mismatch
    if (n >= 3000) begin
      err_count++;
    end
  endtask : wait_done
  // start by the start bit, check busy, length, flag, irq, sampling
  task automatic run_conv(input logic au, input logic [2:0] dv, input int len);
    int d0;
    int t0;
    int s0;
    int p;
    logic [31:0] x;
    d0 = done_cnt;
    s0 = smp_cnt;
    p = (dv < 2) ? 2 : (1 << dv);
    wr(OFF_A, ca(1'b1, au, 1'b0, dv));
    t0 = cyc;
    rd(OFF_A, x);
    chk(32'(x[6]), 32'h1);
    wait_done(d0);
    chk_span(done_at - t0, (len - 1) * p, (len + 1) * p + 4);
    chk(32'(smp_cnt - s0), 32'h1);
    rd(OFF_A, x);
    chk(32'({x[6], x[4]}), 32'h1);
    chk(32'(c_irq), 32'h1);
    wr(OFF_A, ca(1'b0, au, 1'b1, dv));
    @(posedge clk);
    chk(32'(c_irq), 32'h0);
  endtask : run_conv
  // ==========================================================
  // verdict, the single place the run ends
  task automatic results;
    if (err_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results
  // watchdog, well beyond the roughly 1300 cycles the tests take
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    results();
  end
  // ==========================================================
  // main sequence
  initial begin
    logic [31:0] x;
    logic e;
    logic [9:0] r0;
    logic [7:0] sel;
    int d0;
    int t0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    // reset values, read-only result byte, unmapped address
    for (int i = 0; i < 5; i++) begin
      rd(8'(i * 4), x);
      chk(x, 32'h0);
    end
    wr(OFF_LO, 32'hff);
    rd(OFF_LO, x);
    chk(x, 32'h0);
    // high read releases the lock that the low read just took
    rd(OFF_HI, x);
    chk(x, 32'h0);
    apb(1'b0, 8'h14, 32'h0, x, e);
    chk(x, 32'h0);
    chk(32'(e), 32'h1);
    // selections are held off the converter while disabled
    wr(OFF_S, 32'hc7);
    @(posedge clk);
    chk(32'({c_ref, c_ch}), 32'h0);
    wr(OFF_A, ca(1'b0, 1'b0, 1'b0, 3'h0));
    @(posedge clk);
    chk(32'({c_ref, c_ch}), 32'h67);
    // first conversion after enable is the long one
    res_in <= 10'h3c9;
    run_conv(1'b0, 3'h0, 25);
    rd(OFF_LO, x);
    chk(x, rbyte(10'h3c9, 1'b0, 1'b0));
    rd(OFF_HI, x);
    chk(x, rbyte(10'h3c9, 1'b0, 1'b1));
    // random selections, results and dividers
    for (int i = 0; i < 6; i++) begin
      sel = 8'($random(seed));
      sel[4] = 1'b0; // single ended: differential timing differs
      r0 = 10'($random(seed));
      wr(OFF_S, {24'h0, sel});
      res_in <= r0;
      // active selection is a flop one cycle behind the written one
      repeat (2) @(posedge clk);
      chk(32'({c_ref, c_ch}), 32'({sel[7:6], sel[4:0]}));
      run_conv(1'b0, 3'(i % 3), 13);
      rd(OFF_LO, x);
      chk(x, rbyte(r0, sel[5], 1'b0));
      rd(OFF_HI, x);
      chk(x, rbyte(r0, sel[5], 1'b1));
    end
    // channel change in mid conversion waits for its end
    d0 = done_cnt;
    wr(OFF_A, ca(1'b1, 1'b0, 1'b0, 3'h2));
    repeat (8) @(posedge clk);
    wr(OFF_S, {24'h0, sel[7:5], 1'b0, ~sel[3:0]});
    @(posedge clk);
    chk(32'(c_ch), 32'(sel[4:0]));
    wait_done(d0);
    repeat (2) @(posedge clk);
    chk(32'(c_ch), 32'({1'b0, ~sel[3:0]}));
    // low read locks both bytes; completion while locked is lost
    wr(OFF_S, 32'h21);
    res_in <= 10'h2a5;
    run_conv(1'b0, 3'h0, 13);
    rd(OFF_LO, x);
    chk(x, rbyte(10'h2a5, 1'b1, 1'b0));
    res_in <= 10'h15a;
    run_conv(1'b0, 3'h0, 13);
    rd(OFF_HI, x);
    chk(x, rbyte(10'h2a5, 1'b1, 1'b1));
    run_conv(1'b0, 3'h0, 13);
    rd(OFF_LO, x);
    chk(x, rbyte(10'h15a, 1'b1, 1'b0));
    rd(OFF_HI, x);
    chk(x, rbyte(10'h15a, 1'b1, 1'b1));
    // auto trigger on source 3, divider 4
    wr(OFF_B, 32'h3);
    wr(OFF_A, ca(1'b0, 1'b1, 1'b0, 3'h2));
    d0 = done_cnt;
    @(posedge clk);
    trig <= 8'h08;
    t0 = cyc;
    rd(OFF_A, x);
    chk(32'(x[6]), 32'h1);
    wait_done(d0);
    chk_span(done_at - t0, 12 * 4, 14 * 4 + 8);
    // held level and an edge on an unselected source start nothing
    trig <= 8'h28;
    repeat (120) @(posedge clk);
    chk(32'(done_cnt - d0), 32'h1);
    // a second edge during conversion is ignored
    trig <= 8'h00;
    @(posedge clk);
    d0 = done_cnt;
    trig <= 8'h08;
    repeat (20) @(posedge clk);
    trig <= 8'h00;
    @(posedge clk);
    trig <= 8'h08;
    repeat (100) @(posedge clk);
    chk(32'(done_cnt - d0), 32'h1);
    // start bit still works with auto trigger on
    trig <= 8'h00;
    run_conv(1'b1, 3'h2, 13);
    // own completion as source: free running, flag never cleared,
    // differential channel so every restart takes 14 cycles
    wr(OFF_S, 32'h31);
    wr(OFF_B, 32'h0);
    d0 = done_cnt;
    wr(OFF_A, ca(1'b1, 1'b1, 1'b0, 3'h1));
    wait_done(d0);
    wait_done(d0 + 1);
    t0 = done_at;
    wait_done(d0 + 2);
    chk_span(done_at - t0, 14 * 2, 14 * 2);
    rd(OFF_A, x);
    chk(32'({x[6], x[4]}), 32'h3);
    // disable aborts and blanks the selections
    wr(OFF_A, 32'h0);
    // let a completion pulse launched at the write edge be counted first
    repeat (2) @(posedge clk);
    d0 = done_cnt;
    chk(32'({c_busy, c_ref, c_ch}), 32'h0);
    repeat (80) @(posedge clk);
    chk(32'(done_cnt - d0), 32'h0);
    run_conv(1'b0, 3'h0, 25);
    results();
  end
endmodule : test_adc_conversion_sequencer
`default_nettype wire
